//--- pkg/ee_capture_pkg.sv
// constants for the data eeprom address capture block
// assumes an apb slave at 10 MHz system clock, word-aligned registers
`default_nettype none
package ee_capture_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  // register indices; each register is one word, byte address = 4 * index
  localparam logic [11:0] CONTROL_IDX    = 12'h760;
  localparam logic [11:0] KEY_IDX        = 12'h766;
  localparam logic [11:0] CAPTURE_IDX    = 12'h780;
  localparam logic [11:0] TARGET_IDX     = 12'h784;
  localparam logic [13:0] CONTROL_ADDR   = {CONTROL_IDX, 2'b00};
  localparam logic [13:0] KEY_ADDR       = {KEY_IDX, 2'b00};
  localparam logic [13:0] CAPTURE_ADDR   = {CAPTURE_IDX, 2'b00};
  localparam logic [13:0] TARGET_ADDR    = {TARGET_IDX, 2'b00};

  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] KEY_RESET      = 16'h0000;

  // ****************************************************
  // control field positions
  // ****************************************************
  localparam int CTL_START_BIT    = 15;
  localparam int CTL_ALLOW_BIT    = 14;
  localparam int CTL_FAULT_BIT    = 13;
  localparam int CTL_NOERASE_BIT  = 12;
  localparam int CTL_ERASE_BIT    = 6;
  localparam int CTL_OPCODE_LSB   = 0;
  localparam int OPCODE_W         = 6;
  localparam logic [15:0] CONTROL_WMASK = 16'hF07F;
  localparam logic [15:0] KEY_WMASK     = 16'h00FF;

  // ****************************************************
  // operation codes (erase/write kinds)
  // ****************************************************
  localparam logic [5:0] OP_ERASE_1 = 6'h18;
  localparam logic [5:0] OP_ERASE_4 = 6'h19;
  localparam logic [5:0] OP_ERASE_8 = 6'h1A;
  localparam logic [5:0] OP_BULK    = 6'h1B;
  localparam logic [5:0] OP_WRITE_1 = 6'h04;

  // ****************************************************
  // address layout
  // ****************************************************
  localparam int EA_W      = 24;
  localparam int UPPER_W   = 8;
  localparam int LOWER_W   = 16;
  localparam int ROW_WORDS = 8;

endpackage
`default_nettype wire

//--- pkg/ee_capture_if.sv
// bundle from the capture latch to the register/op logic
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface ee_capture_if;
  logic        wr_valid;
  logic [23:0] wr_ea;
  logic [7:0]  upper;
  logic [15:0] lower;
  modport latch (input wr_valid, input wr_ea, output upper, output lower);
  modport user  (output wr_valid, output wr_ea, input upper, input lower);
endinterface : ee_capture_if
`default_nettype wire

//--- rtl/ee_address_latch.sv
// captured effective address of the last table write
// assumes table-write strobe from core logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module ee_address_latch
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  ee_capture_if.latch    cap
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap.upper <= 8'h00;
      cap.lower <= 16'h0000;
    end
    else if (cap.wr_valid)
    begin
      cap.upper <= {1'b0, cap.wr_ea[22:16]};
      cap.lower <= {cap.wr_ea[15:1], 1'b0};
    end
  end

  property p_msb_zero;
    @(posedge clk) disable iff (!rst_n) cap.upper[7] == 1'b0;
  endproperty
  a_msb_zero: assert property (p_msb_zero)
    else $error("upper capture msb set");

  property p_lsb_zero;
    @(posedge clk) disable iff (!rst_n) cap.lower[0] == 1'b0;
  endproperty
  a_lsb_zero: assert property (p_lsb_zero)
    else $error("lower capture lsb set");

  property p_latch;
    @(posedge clk) disable iff (!rst_n)
      cap.wr_valid |=> cap.lower[15:1] == $past(cap.wr_ea[15:1])
        && cap.upper[6:0] == $past(cap.wr_ea[22:16]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("capture missed table write address");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !cap.wr_valid |=> $stable(cap.lower) && $stable(cap.upper);
  endproperty
  a_hold: assert property (p_hold)
    else $error("capture changed without table write");

endmodule // ee_address_latch
`default_nettype wire

//--- rtl/ee_capture_top.sv
// data eeprom address capture with control and key registers
// assumes apb master on CLK_SYS, table-write strobe from the core
// Notes on behaviour
// - the effective address is 24 bits, top 8 from upper, low 16 from lower.
// - every table write loads address bits 22 to 1 into the capture registers.
// - capture registers are not writable by bus writes, only by table writes.
// - the captured address selects the row or word that an operation hits.
// - the lowest bit of the lower capture register always reads zero.
// - only the low 16-bit word of each table write's data is stored.
// - the highest bit of the upper capture register always reads zero.
// - erase of one, four, eight words, bulk erase and word write.
`timescale 1ns/100ps
`default_nettype none
module ee_capture_top
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [13:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TBL_WRITE,
  input  wire logic [23:0] TBL_EA,
  input  wire logic [15:0] TBL_DATA,
  output logic             OP_START,
  output logic      [5:0]  OP_CODE,
  output logic             OP_ERASE,
  output logic             OP_NOERASE,
  output logic      [23:0] OP_ADDR,
  output logic      [3:0]  OP_WORDS,
  output logic      [15:0] OP_DATA,
  output logic             OP_BULK,
  input  wire logic        OP_DONE,
  input  wire logic        OP_FAULT
);

  // ****************************************************
  // reset release
  // ****************************************************
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************************
  // capture latch
  // ****************************************************
  ee_capture_if cap ();
  assign cap.wr_valid = TBL_WRITE;
  assign cap.wr_ea    = TBL_EA;

  ee_address_latch u_latch
  (
    .clk   (CLK_SYS),
    .rst_n (rst_n_q),
    .cap   (cap)
  );

  logic [23:0] ea;
  assign ea = {cap.upper, cap.lower};

  // write data latch: only the low word exists
  logic [15:0] data_q;
  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
      data_q <= 16'h0000;
    else if (TBL_WRITE)
      data_q <= TBL_DATA;
  end

  // ****************************************************
  // apb slave
  // ****************************************************
  logic        setup;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  assign setup  = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = setup && !PWRITE;
  assign mapped = PADDR == ee_capture_pkg::CONTROL_ADDR
    || PADDR == ee_capture_pkg::KEY_ADDR
    || PADDR == ee_capture_pkg::CAPTURE_ADDR
    || PADDR == ee_capture_pkg::TARGET_ADDR;

  logic [15:0] control_q;
  logic [15:0] key_q;
  logic        busy_q;
  logic        wr_ctl;
  logic        start_req;
  assign wr_ctl    = wr_acc && PADDR == ee_capture_pkg::CONTROL_ADDR;
  assign start_req = wr_ctl && !busy_q
    && PWDATA[ee_capture_pkg::CTL_START_BIT]
    && control_q[ee_capture_pkg::CTL_ALLOW_BIT];

  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
      key_q <= ee_capture_pkg::KEY_RESET;
    else if (wr_acc && PADDR == ee_capture_pkg::KEY_ADDR)
      key_q <= PWDATA[15:0] & ee_capture_pkg::KEY_WMASK;
  end

  // hardware clears start and sets fault; fault set wins over a software clear
  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
      control_q <= ee_capture_pkg::CONTROL_RESET;
    else
    begin
      if (wr_ctl && !busy_q)
      begin
        control_q <= PWDATA[15:0] & ee_capture_pkg::CONTROL_WMASK;
        control_q[ee_capture_pkg::CTL_START_BIT] <= start_req;
      end
      if (OP_DONE && busy_q)
        control_q[ee_capture_pkg::CTL_START_BIT] <= 1'b0;
      if (OP_DONE && busy_q && OP_FAULT)
        control_q[ee_capture_pkg::CTL_FAULT_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      if (rd_acc)
        unique case (PADDR)
          ee_capture_pkg::CONTROL_ADDR: PRDATA <= {16'h0000, control_q};
          ee_capture_pkg::KEY_ADDR:     PRDATA <= 32'h0000_0000;
          ee_capture_pkg::CAPTURE_ADDR: PRDATA <= {8'h00, ea};
          ee_capture_pkg::TARGET_ADDR:  PRDATA <= {16'h0000, data_q};
          default:                      PRDATA <= 32'h0000_0000;
        endcase
    end
  end

  // ****************************************************
  // operation launch
  // ****************************************************
  logic [3:0] words;
  logic [5:0] op;
  logic       bulk;
  always_comb
  begin
    op    = PWDATA[5:0];
    bulk  = 1'b0;
    words = 4'h1;
    if (PWDATA[ee_capture_pkg::CTL_ERASE_BIT])
      unique case (op)
        ee_capture_pkg::OP_ERASE_4: words = 4'h4;
        ee_capture_pkg::OP_ERASE_8: words = 4'h8;
        ee_capture_pkg::OP_BULK:    bulk  = 1'b1;
        default:                    words = 4'h1;
      endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      busy_q     <= 1'b0;
      OP_START   <= 1'b0;
      OP_CODE    <= 6'h00;
      OP_ERASE   <= 1'b0;
      OP_NOERASE <= 1'b0;
      OP_ADDR    <= 24'h00_0000;
      OP_WORDS   <= 4'h0;
      OP_DATA    <= 16'h0000;
      OP_BULK    <= 1'b0;
    end
    else
    begin
      OP_START <= start_req;
      if (start_req)
      begin
        busy_q     <= 1'b1;
        OP_CODE    <= op;
        OP_ERASE   <= PWDATA[ee_capture_pkg::CTL_ERASE_BIT];
        OP_NOERASE <= PWDATA[ee_capture_pkg::CTL_NOERASE_BIT];
        OP_ADDR    <= ea;
        OP_WORDS   <= words;
        OP_DATA    <= data_q;
        OP_BULK    <= bulk;
      end
      else if (OP_DONE)
        busy_q <= 1'b0;
    end
  end

  property p_launch;
    @(posedge CLK_SYS) disable iff (!rst_n_q)
      start_req |=> OP_START && OP_ADDR == $past(ea) && busy_q;
  endproperty
  a_launch: assert property (p_launch)
    else $error("operation address not taken from capture");

  property p_ea_split;
    @(posedge CLK_SYS) disable iff (!rst_n_q)
      TBL_WRITE |=> ea == {1'b0, $past(TBL_EA[22:1]), 1'b0};
  endproperty
  a_ea_split: assert property (p_ea_split)
    else $error("effective address misassembled");

  property p_no_bus_load;
    @(posedge CLK_SYS) disable iff (!rst_n_q)
      (wr_acc && !TBL_WRITE) |=> $stable(ea);
  endproperty
  a_no_bus_load: assert property (p_no_bus_load)
    else $error("bus write changed captured address");

  property p_data_low;
    @(posedge CLK_SYS) disable iff (!rst_n_q)
      TBL_WRITE |=> data_q == $past(TBL_DATA);
  endproperty
  a_data_low: assert property (p_data_low)
    else $error("low word not stored");

  property p_erase8;
    @(posedge CLK_SYS) disable iff (!rst_n_q)
      (start_req && PWDATA[ee_capture_pkg::CTL_ERASE_BIT]
        && PWDATA[5:0] == ee_capture_pkg::OP_ERASE_8) |=> OP_WORDS == 4'h8;
  endproperty
  a_erase8: assert property (p_erase8)
    else $error("eight word erase size wrong");

endmodule // ee_capture_top
`default_nettype wire

//--- verif/ee_engine_model.sv
// model of the eeprom erase/program engine beside the block
// assumes the launch pulse arrives on the same clock
`timescale 1ns/100ps
`default_nettype none
module ee_engine_model
#(
  parameter int DELAY = 6
)
(
  input  wire logic clk,
  input  wire logic start,
  input  wire logic fault_req,
  output logic      done,
  output logic      fault
);
  int cnt = 0;
  // one done pulse DELAY cycles after launch
  always @(posedge clk)
  begin
    done  <= (cnt == 1);
    fault <= (cnt == 1) && fault_req;
    cnt   <= start ? DELAY : ((cnt > 0) ? cnt - 1 : 0);
  end
endmodule // ee_engine_model
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the eeprom address capture block
// assumes the engine model and the apb/table-write tasks below
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, err, tbl_write = 1'b0;
  logic [23:0] tbl_ea = 24'h0, op_addr;
  logic [15:0] tbl_data = 16'h0, op_data;
  logic        op_start, op_erase, op_noerase, op_bulk, done, flt;
  logic        fault_req = 1'b0;
  logic [5:0]  op_code;
  logic [3:0]  op_words;
  logic [35:0] seen;
  logic [16:0] seen_d;
  logic [24:0] nb;
  int          fails = 0, compares = 0;
  logic [6:0]  ops [5] = '{7'h58, 7'h59, 7'h5A, 7'h5B, 7'h04};
  logic [3:0]  wds [5] = '{4'h1, 4'h4, 4'h8, 4'h0, 4'h1};
  logic [23:0] ea;

  initial
  begin
    forever #50 clk = ~clk;
  end

  ee_capture_top uut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TBL_WRITE(tbl_write), .TBL_EA(tbl_ea), .TBL_DATA(tbl_data),
    .OP_START(op_start), .OP_CODE(op_code), .OP_ERASE(op_erase),
    .OP_NOERASE(op_noerase), .OP_ADDR(op_addr), .OP_WORDS(op_words),
    .OP_DATA(op_data), .OP_BULK(op_bulk), .OP_DONE(done), .OP_FAULT(flt));

  ee_engine_model eng (.clk(clk), .start(op_start), .fault_req(fault_req),
    .done(done), .fault(flt));

  // ****************************************************
  // launch monitor
  // ****************************************************
  always @(posedge clk)
  begin
    if (op_start === 1'b1)
    begin
      seen   <= {op_bulk, op_erase, op_words, op_code, op_addr};
      seen_d <= {op_noerase, op_data};
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [13:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tw(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    tbl_write <= 1'b1;
    tbl_ea    <= a;
    tbl_data  <= d;
    @(posedge clk);
    tbl_write <= 1'b0;
  endtask

  task automatic test_done;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************
  // tests
  // ****************************************************
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, ee_capture_pkg::CONTROL_ADDR, 32'h0);
    chk(r, 36'h0);
    apb(1'b1, ee_capture_pkg::KEY_ADDR, 32'h55);
    apb(1'b0, ee_capture_pkg::KEY_ADDR, 32'h0);
    chk(r, 36'h0);
    apb(1'b0, 14'h1FC0, 32'h0);
    chk(err, 36'h1);
    tw(24'hFFFFFF, 16'h1234);
    apb(1'b0, ee_capture_pkg::CAPTURE_ADDR, 32'h0);
    chk(r, 36'h7FFFFE);
    chk(err, 36'h0);
    apb(1'b1, ee_capture_pkg::CAPTURE_ADDR, 32'h0);
    apb(1'b0, ee_capture_pkg::CAPTURE_ADDR, 32'h0);
    chk(r, 36'h7FFFFE);
    for (int i = 0; i < 5; i++)
    begin
      ea = 24'h2468AD + 24'(i * 16);
      fault_req <= (i == 4);
      tw(ea, 16'hBEE0 + 16'(i));
      apb(1'b0, ee_capture_pkg::TARGET_ADDR, 32'h0);
      chk(r, 36'hBEE0 + 36'(i));
      nb = (i == 4) ? 25'h020 : 25'h000;
      apb(1'b1, ee_capture_pkg::CONTROL_ADDR, {25'h080 | nb, ops[i]});
      apb(1'b1, ee_capture_pkg::CONTROL_ADDR, {25'h180 | nb, ops[i]});
      // write while busy must be dropped
      apb(1'b1, ee_capture_pkg::CONTROL_ADDR, 32'h0);
      repeat (12) @(posedge clk);
      chk(seen[23:0], ea & 24'h7FFFFE);
      chk(seen[35:34], {i == 3, ops[i][6]});
      chk(seen[29:24], ops[i][5:0]);
      chk(seen_d, {i == 4, 16'hBEE0 + 16'(i)});
      if (i != 3)
        chk(seen[33:30], wds[i]);
      // read control back after the engine finished: start clear, allow kept
      apb(1'b0, ee_capture_pkg::CONTROL_ADDR, 32'h0);
      chk(r, {20'h0, 2'b01, i == 4, i == 4, 5'h0, ops[i]});
    end
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
